// ---- hw/pxs_regs.sv ----
/*
 * Proximity sensor front end: two-wire serial slave with command byte
 * decode, enable/timing registers and the measurement sequencer.
 * Assumes pins arrive asynchronously and SDA is open drain outside;
 * i_prox_hit is the analog compare result on the core clock.
 */
// Behaviour
// - Bits 6:5 select transaction type
// - Type 00 keeps the pointer fixed
// - Type 01 advances pointer each byte
// - Bits 4:0 are function or address
// - Code 00101 clears interrupt, 00000 nothing
// - Interrupt clear is a one-shot
// - Bit 6 enables sleep after interrupt
// - Bit 5 masks proximity interrupts
// - Bit 3 enables wait timer
// - Bit 2 enables proximity measurement
// - Bit 0 runs oscillator and timers
// - Integration steps 2.73ms, reset 0xFF
// - Wait steps are 256 minus value
// - Wait register resets to 0xFF
// - Wait-long makes steps twelve times longer
// - Init, accumulate, wait, converter sequence
// - Interrupt at converter end, then sleep
// - Flagless bytes write at kept pointer
// - Configuration bit 1 is wait-long
`default_nettype none

module pxs_regs #(
   parameter logic [6:0]  DEV_ADDR    = 7'h2a, // arbitrary value
   parameter int unsigned STEP_CYCLES = pxs_pkg::STEP_CYCLES
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   // Serial bus pins
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_sda_o,
   output logic      o_sda_oe,
   // Analog side
   input  wire logic i_prox_hit,
   // Status
   output logic      o_prox_irq,
   output logic      o_osc_run,
   output logic      o_accum_active,
   output logic      o_adc_active
);

   import pxs_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisation and bus conditions
   // ----------------------------------------------------------------
   logic scl_s;
   logic sda_s;
   logic scl_d1_q;
   logic sda_d1_q;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   pxs_sync #(.RST_VAL(1'b1)) u_sync_scl (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_d     (i_scl),
      .o_q     (scl_s)
   );

   pxs_sync #(.RST_VAL(1'b1)) u_sync_sda (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_d     (i_sda),
      .o_q     (sda_s)
   );

   // Previous synchronised levels for edge detection
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         scl_d1_q <= 1'b1;
         sda_d1_q <= 1'b1;
      end else begin
         scl_d1_q <= scl_s;
         sda_d1_q <= sda_s;
      end
   end

   // Start and stop are SDA edges while SCL stays high
   assign scl_rise  = scl_s & ~scl_d1_q;
   assign scl_fall  = ~scl_s & scl_d1_q;
   assign start_det = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
   assign stop_det  = scl_s & scl_d1_q & ~sda_d1_q & sda_s;

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [7:0] enables_q;
   logic [7:0] integ_q;
   logic [7:0] wait_q;
   logic [7:0] config_q;
   logic [1:0] type_q;
   logic [4:0] ptr_q;
   logic       prox_irq_q;

   // Serial engine state
   pxs_bus_e   bus_st_q;
   logic [7:0] shreg_q;
   logic [2:0] bitcnt_q;
   logic       done_q;
   logic       rw_q;
   logic       first_q;
   logic       nack_q;
   logic       sda_oe_q;
   logic       sda_o_q;

   // Byte events and decoded strobes
   logic       byte_ev;
   logic       is_cmd;
   logic       wr_data_ev;
   logic       rd_byte_ev;
   logic       sf_clear;
   logic       irq_set;
   logic [4:0] ptr_adv;
   logic [7:0] rd_cur;
   logic [7:0] rd_adv;

   // Read mux; unmapped pointers read zero
   function automatic logic [7:0] read_reg(input logic [4:0] a);
      logic [7:0] r;
      r = 8'h00;
      if (a == ADDR_ENABLES) begin
         r = enables_q;
      end else if (a == ADDR_INTEG) begin
         r = integ_q;
      end else if (a == ADDR_WAIT) begin
         r = wait_q;
      end else if (a == ADDR_CONFIG) begin
         r = config_q;
      end
      return r;
   endfunction

   // Pointer step and byte event decode
   always_comb begin
      ptr_adv    = (type_q == TYPE_AUTOINC) ? ptr_q + 5'h01 : ptr_q;
      rd_cur     = read_reg(ptr_q);
      rd_adv     = read_reg(ptr_adv);
      byte_ev    = scl_fall && (bus_st_q == BUS_WR) && done_q;
      is_cmd     = byte_ev && first_q && shreg_q[BIT_CMD_FLAG];
      wr_data_ev = byte_ev && !is_cmd;
      rd_byte_ev = scl_fall && (bus_st_q == BUS_RACK);
      sf_clear   = is_cmd
                   && (shreg_q[BIT_TYPE_HI:BIT_TYPE_LO] == TYPE_SPECIAL)
                   && (shreg_q[4:0] == SF_PROX_CLR);
   end

   // ----------------------------------------------------------------
   // Command decode: type and pointer
   // ----------------------------------------------------------------
   // kept across stop and start
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         type_q <= TYPE_RST;
         ptr_q  <= PTR_RST;
      end else if (is_cmd) begin
         if (shreg_q[BIT_TYPE_HI:BIT_TYPE_LO] == TYPE_REPEAT ||
             shreg_q[BIT_TYPE_HI:BIT_TYPE_LO] == TYPE_AUTOINC) begin
            type_q <= shreg_q[BIT_TYPE_HI:BIT_TYPE_LO];
            ptr_q  <= shreg_q[4:0];
         end
      end else if (wr_data_ev || rd_byte_ev) begin
         ptr_q <= ptr_adv;
      end
   end

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // integration resets to 0xff
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         enables_q <= ENABLES_RST;
         integ_q   <= INTEG_RST;
         wait_q    <= WAIT_RST;
         config_q  <= CONFIG_RST;
      end else if (wr_data_ev) begin
         if (ptr_q == ADDR_ENABLES) begin
            enables_q <= shreg_q & ENABLES_WR_MASK;
         end else if (ptr_q == ADDR_INTEG) begin
            integ_q <= shreg_q;
         end else if (ptr_q == ADDR_WAIT) begin
            wait_q <= shreg_q;
         end else if (ptr_q == ADDR_CONFIG) begin
            config_q <= shreg_q & CONFIG_WR_MASK;
         end
      end
   end

   // Pending interrupt; a new event beats a clear in the same cycle
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         prox_irq_q <= 1'b0;
      end else if (irq_set) begin
         prox_irq_q <= 1'b1;
      end else if (sf_clear) begin
         prox_irq_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Serial engine
   // ----------------------------------------------------------------
   // Sample on SCL rise, change SDA after SCL fall; no clock stretching
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         bus_st_q <= BUS_IDLE;
         shreg_q  <= 8'h00;
         bitcnt_q <= 3'h0;
         done_q   <= 1'b0;
         rw_q     <= 1'b0;
         first_q  <= 1'b0;
         nack_q   <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (start_det) begin
         bus_st_q <= BUS_ADDR;
         bitcnt_q <= 3'h0;
         done_q   <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (stop_det) begin
         bus_st_q <= BUS_IDLE;
         done_q   <= 1'b0;
         sda_oe_q <= 1'b0;
      end else begin
         case (bus_st_q)
            BUS_ADDR, BUS_WR: begin
               if (scl_rise) begin
                  shreg_q  <= {shreg_q[6:0], sda_s};
                  bitcnt_q <= bitcnt_q + 3'h1;
                  if (bitcnt_q == 3'h7) begin
                     done_q <= 1'b1;
                  end
               end else if (scl_fall && done_q) begin
                  done_q <= 1'b0;
                  if (bus_st_q == BUS_WR) begin
                     sda_oe_q <= 1'b1;
                     first_q  <= 1'b0;
                     bus_st_q <= BUS_WACK;
                  end else if (shreg_q[7:1] == DEV_ADDR) begin
                     sda_oe_q <= 1'b1;
                     rw_q     <= shreg_q[0];
                     bus_st_q <= BUS_AACK;
                  end else begin
                     bus_st_q <= BUS_IDLE;
                  end
               end
            end
            BUS_AACK: begin
               if (scl_fall) begin
                  bitcnt_q <= 3'h0;
                  if (rw_q) begin
                     shreg_q  <= rd_cur;
                     sda_oe_q <= ~rd_cur[7];
                     bus_st_q <= BUS_RD;
                  end else begin
                     sda_oe_q <= 1'b0;
                     first_q  <= 1'b1;
                     bus_st_q <= BUS_WR;
                  end
               end
            end
            BUS_WACK: begin
               if (scl_fall) begin
                  sda_oe_q <= 1'b0;
                  bitcnt_q <= 3'h0;
                  bus_st_q <= BUS_WR;
               end
            end
            BUS_RD: begin
               if (scl_rise) begin
                  bitcnt_q <= bitcnt_q + 3'h1;
                  if (bitcnt_q == 3'h7) begin
                     done_q <= 1'b1;
                  end
               end else if (scl_fall) begin
                  if (done_q) begin
                     done_q   <= 1'b0;
                     sda_oe_q <= 1'b0;
                     bus_st_q <= BUS_RACK;
                  end else begin
                     shreg_q  <= {shreg_q[6:0], 1'b0};
                     sda_oe_q <= ~shreg_q[6];
                  end
               end
            end
            BUS_RACK: begin
               if (scl_rise) begin
                  nack_q <= sda_s;
               end else if (scl_fall) begin
                  if (nack_q) begin
                     bus_st_q <= BUS_IDLE;
                  end else begin
                     shreg_q  <= rd_adv;
                     sda_oe_q <= ~rd_adv[7];
                     bitcnt_q <= 3'h0;
                     bus_st_q <= BUS_RD;
                  end
               end
            end
            default: begin
               bus_st_q <= BUS_IDLE;
            end
         endcase
      end
   end

   // Open drain: the data level is always low, only the enable moves
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sda_o_q <= 1'b0;
      end else begin
         sda_o_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Measurement sequencer
   // ----------------------------------------------------------------
   pxs_meas_e   meas_st_q;
   logic        tmr_start_q;
   logic [11:0] tmr_units_q;
   logic        tmr_done;
   logic [11:0] accum_cnt_q;
   logic [8:0]  wait_base;
   logic [11:0] adc_steps;
   logic [11:0] wait_steps;
   logic        osc_on;
   logic        prox_on;
   logic        wait_on;

   assign osc_on  = enables_q[BIT_OSC_ON];
   assign prox_on = enables_q[BIT_PROX_EN];
   assign wait_on = enables_q[BIT_WAIT_EN];

   // Step counts: two's complement of the register, up to 3072
   always_comb begin
      adc_steps  = 12'(STEP_MODULUS - {1'b0, integ_q});
      wait_base  = STEP_MODULUS - {1'b0, wait_q};
      wait_steps = config_q[BIT_WAIT_X12] ? 12'(wait_base) * 12'(WAIT_STRETCH)
                                           : 12'(wait_base);
      irq_set    = (meas_st_q == M_ADC) && tmr_done
                   && enables_q[BIT_IRQ_MASK] && i_prox_hit;
   end

   pxs_step_timer #(.UNIT_CYCLES(STEP_CYCLES)) u_step_timer (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_clear (~osc_on),
      .i_start (tmr_start_q),
      .i_units (tmr_units_q),
      .o_done  (tmr_done)
   );

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meas_st_q   <= M_OFF;
         tmr_start_q <= 1'b0;
         tmr_units_q <= ONE_STEP;
         accum_cnt_q <= 12'h000;
      end else begin
         tmr_start_q <= 1'b0;
         if (!osc_on) begin
            meas_st_q <= M_OFF;
         end else if (!prox_on && (meas_st_q == M_INIT ||
                      meas_st_q == M_ACCUM || meas_st_q == M_PWAIT ||
                      meas_st_q == M_ADC)) begin
            meas_st_q <= M_OFF;
         end else begin
            case (meas_st_q)
               M_OFF, M_SLEEP: begin
                  // Sleep holds until the interrupt is cleared
                  if (meas_st_q == M_OFF || !prox_irq_q) begin
                     if (prox_on) begin
                        meas_st_q   <= M_INIT;
                        tmr_units_q <= ONE_STEP;
                        tmr_start_q <= 1'b1;
                     end else if (wait_on) begin
                        meas_st_q   <= M_WAIT;
                        tmr_units_q <= wait_steps;
                        tmr_start_q <= 1'b1;
                     end else begin
                        meas_st_q <= M_OFF;
                     end
                  end
               end
               M_INIT: begin
                  if (tmr_done) begin
                     meas_st_q   <= M_ACCUM;
                     accum_cnt_q <= ACCUM_CYCLES - 12'h001;
                  end
               end
               M_ACCUM: begin
                  if (accum_cnt_q == 12'h000) begin
                     meas_st_q   <= M_PWAIT;
                     tmr_units_q <= ONE_STEP;
                     tmr_start_q <= 1'b1;
                  end else begin
                     accum_cnt_q <= accum_cnt_q - 12'h001;
                  end
               end
               M_PWAIT: begin
                  if (tmr_done) begin
                     meas_st_q   <= M_ADC;
                     tmr_units_q <= adc_steps;
                     tmr_start_q <= 1'b1;
                  end
               end
               M_ADC: begin
                  if (tmr_done) begin
                     if (irq_set && enables_q[BIT_SLEEP_IRQ]) begin
                        meas_st_q <= M_SLEEP;
                     end else if (wait_on) begin
                        meas_st_q   <= M_WAIT;
                        tmr_units_q <= wait_steps;
                        tmr_start_q <= 1'b1;
                     end else begin
                        meas_st_q <= M_OFF;
                     end
                  end
               end
               M_WAIT: begin
                  if (tmr_done) begin
                     meas_st_q <= M_OFF;
                  end
               end
               default: begin
                  meas_st_q <= M_OFF;
               end
            endcase
         end
      end
   end

   // Registered status copies
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_osc_run      <= 1'b0;
         o_accum_active <= 1'b0;
         o_adc_active   <= 1'b0;
      end else begin
         o_osc_run      <= osc_on;
         o_accum_active <= (meas_st_q == M_ACCUM);
         o_adc_active   <= (meas_st_q == M_ADC);
      end
   end

   assign o_sda_o    = sda_o_q;
   assign o_sda_oe   = sda_oe_q;
   assign o_prox_irq = prox_irq_q;

endmodule // pxs_regs

`default_nettype wire

// ---- hw/pxs_step_timer.sv ----
/*
 * Step timer: counts a number of fixed-length units, then pulses done.
 * Assumes i_start only while idle or restarting; i_clear stops it at once.
 */
`default_nettype none

module pxs_step_timer #(
   parameter int unsigned UNIT_CYCLES = 109200
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   // Control
   input  wire logic        i_clear,
   input  wire logic        i_start,
   input  wire logic [11:0] i_units,
   // Status
   output logic             o_done
);

   localparam logic [16:0] PRE_LAST = 17'(UNIT_CYCLES - 1);

   logic [16:0] pre_q;
   logic [11:0] left_q;
   logic        busy_q;

   // Prescaler and unit counter; zero units behaves as one
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pre_q  <= 17'h00000;
         left_q <= 12'h000;
         busy_q <= 1'b0;
         o_done <= 1'b0;
      end else if (i_clear) begin
         pre_q  <= 17'h00000;
         busy_q <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_start) begin
            busy_q <= 1'b1;
            left_q <= i_units;
            pre_q  <= 17'h00000;
         end else if (busy_q) begin
            if (pre_q == PRE_LAST) begin
               pre_q <= 17'h00000;
               if (left_q <= 12'h001) begin
                  busy_q <= 1'b0;
                  o_done <= 1'b1;
               end else begin
                  left_q <= left_q - 12'h001;
               end
            end else begin
               pre_q <= pre_q + 17'h00001;
            end
         end
      end
   end

endmodule // pxs_step_timer

`default_nettype wire

// ---- hw/pxs_sync.sv ----
/*
 * Two flip-flop synchroniser for one pin input.
 * Assumes the pin is asynchronous to i_clk; reset value is selectable.
 */
`default_nettype none

module pxs_sync #(
   parameter logic RST_VAL = 1'b1
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   // Data
   input  wire logic i_d,
   output logic      o_q
);

   logic meta_q;

   // Only the second stage is visible outside
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_q <= RST_VAL;
         o_q    <= RST_VAL;
      end else begin
         meta_q <= i_d;
         o_q    <= meta_q;
      end
   end

endmodule // pxs_sync

`default_nettype wire

// ---- include/pxs_pkg.sv ----
/*
 * Shared constants and types of the proximity sensor register front end.
 * Assumes a 40 MHz core clock; all timing counts derive from that rate.
 */
`default_nettype none

package pxs_pkg;

   // -----------------------------------------------------------------
   // Register pointer values
   // -----------------------------------------------------------------
   localparam logic [4:0] ADDR_ENABLES = 5'h00;
   localparam logic [4:0] ADDR_INTEG   = 5'h02;
   localparam logic [4:0] ADDR_WAIT    = 5'h03;
   localparam logic [4:0] ADDR_CONFIG  = 5'h0d;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int BIT_CMD_FLAG   = 7;
   localparam int BIT_TYPE_HI    = 6;
   localparam int BIT_TYPE_LO    = 5;
   localparam int BIT_SLEEP_IRQ  = 6;
   localparam int BIT_IRQ_MASK   = 5;
   localparam int BIT_WAIT_EN    = 3;
   localparam int BIT_PROX_EN    = 2;
   localparam int BIT_OSC_ON     = 0;
   localparam int BIT_WAIT_X12   = 1;

   // Writable bits; reserved bits are not stored and read as zero
   localparam logic [7:0] ENABLES_WR_MASK = 8'h6d;
   localparam logic [7:0] CONFIG_WR_MASK  = 8'h02;

   // -----------------------------------------------------------------
   // Command byte encodings
   // -----------------------------------------------------------------
   localparam logic [1:0] TYPE_REPEAT  = 2'h0;
   localparam logic [1:0] TYPE_AUTOINC = 2'h1;
   localparam logic [1:0] TYPE_SPECIAL = 2'h3;
   localparam logic [4:0] SF_NOP       = 5'h00;
   localparam logic [4:0] SF_PROX_CLR  = 5'h05;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] ENABLES_RST = 8'h00;
   localparam logic [7:0] INTEG_RST   = 8'hff;
   localparam logic [7:0] WAIT_RST    = 8'hff;
   localparam logic [7:0] CONFIG_RST  = 8'h00;
   localparam logic [1:0] TYPE_RST    = 2'h0;
   localparam logic [4:0] PTR_RST     = 5'h00;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned STEP_TIME_US  = 2730;
   localparam int unsigned STEP_CYCLES   =
      (STEP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned ACCUM_TIME_NS = 64000;
   localparam logic [11:0] ACCUM_CYCLES  =
      12'((ACCUM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [8:0]  STEP_MODULUS  = 9'h100;
   localparam logic [3:0]  WAIT_STRETCH  = 4'hc;
   localparam logic [11:0] ONE_STEP      = 12'h001;

   // -----------------------------------------------------------------
   // State types
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      BUS_IDLE, BUS_ADDR, BUS_AACK, BUS_WR, BUS_WACK, BUS_RD, BUS_RACK
   } pxs_bus_e;

   typedef enum logic [2:0] {
      M_OFF, M_INIT, M_ACCUM, M_PWAIT, M_ADC, M_WAIT, M_SLEEP
   } pxs_meas_e;

endpackage

`default_nettype wire

// ---- tb/pxs_host.sv ----
/* Host model: serial bus controller, open-drain data pull.
   Assumes the bench resolves SDA with a pull-up. */
`default_nettype none

module pxs_host (
   // Clock and bus
   input  wire logic i_clk,
   input  wire logic i_sda,
   output var  logic o_scl,
   output var  logic o_sda_low
);
   timeunit 1ns;
   timeprecision 100ps;
   // --
   // Bus phases
   // --
   // Idle released, both lines high
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // Quarter bit of 5 clocks keeps SDA clear of SCL edges
   task automatic step(input logic lo, input logic cl);
      repeat (5) @(posedge i_clk);
      #1;
      o_sda_low = lo;
      o_scl = cl;
   endtask
   task automatic start;
      step(1'b0, 1'b0);
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
   endtask
   task automatic stop;
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
   endtask
   task automatic xfer(input logic [7:0] w, input logic nak,
                       output logic [8:0] r);
      logic b;
      for (int i = 8; i >= 0; i--) begin
         b = (i > 0) ? !w[i-1] : !nak;
         step(b, 1'b0);
         step(b, 1'b1);
         repeat (4) @(posedge i_clk);
         r[i] = i_sda;
         step(b, 1'b0);
      end
   endtask
endmodule // pxs_host

`default_nettype wire

// ---- tb/pxs_regs_chk.sv ----
/* Port checker of the front end, bound below.
   Assumes STEP_CYCLES as in the bound instance. */
`default_nettype none

module pxs_regs_chk
   import pxs_pkg::*;
   #(parameter int unsigned STEP_CYCLES = 20)
   (input wire logic i_clk, i_rst_b, i_scl, i_sda, o_sda_o, o_sda_oe,
    input wire logic i_prox_hit, o_prox_irq, o_osc_run, o_accum_active,
    input wire logic o_adc_active);
   localparam int P_LO = STEP_CYCLES - 2;
   localparam int P_HI = STEP_CYCLES + 8;
   logic [11:0] run_q;
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   // --
   // Checks
   // --
   // Accumulate run length, cleared outside the state
   always_ff @(posedge i_clk or negedge i_rst_b)
      if (!i_rst_b)
         run_q <= 12'h000;
      else
         run_q <= o_accum_active ? run_q + 12'h001 : 12'h000;
   accum_len_a: assert property (
      $fell(o_accum_active) && o_osc_run |-> run_q == ACCUM_CYCLES)
      else $error("accumulate length wrong");
   pwait_len_a: assert property (
      $fell(o_accum_active) && o_osc_run |->
      ##[P_LO:P_HI] $rose(o_adc_active))
      else $error("converter did not follow wait");
   irq_source_a: assert property (
      $rose(o_prox_irq) |-> o_adc_active || $past(o_adc_active))
      else $error("interrupt outside converter end");
   irq_hold_a: assert property (
      $fell(o_prox_irq) |-> !i_scl)
      else $error("interrupt dropped without command");
   ack_timing_a: assert property (
      $changed(o_sda_oe) |-> !i_scl)
      else $error("data pull changed while clock high");
   accum_osc_a: assert property (
      o_accum_active |-> o_osc_run || $past(o_osc_run))
      else $error("accumulate without oscillator");
   adc_excl_a: assert property (
      o_adc_active |-> !o_accum_active)
      else $error("two states active");
   init_first_a: assert property (
      $rose(o_accum_active) |-> $past(o_osc_run, 8))
      else $error("accumulate without init");
endmodule // pxs_regs_chk

bind pxs_regs pxs_regs_chk #(.STEP_CYCLES(STEP_CYCLES)) chk (
   .i_clk(i_clk), .i_rst_b(i_rst_b), .i_scl(i_scl), .i_sda(i_sda),
   .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_prox_hit(i_prox_hit),
   .o_prox_irq(o_prox_irq), .o_osc_run(o_osc_run),
   .o_accum_active(o_accum_active), .o_adc_active(o_adc_active));

`default_nettype wire

// ---- tb/test_pxs_regs.sv ----
/* Bench: bus tasks and register checks of the front end.
   Assumes the host model paces every bit on i_clk. */
`default_nettype none

module test_pxs_regs;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clk, i_rst_b, i_prox_hit, scl, sda_low;
   logic o_sda_o, o_sda_oe, o_prox_irq, o_osc_run, o_acc, o_adc;
   logic [8:0] r;
   int fail_count, checked;
   // Pull-up: low while either side pulls
   wire logic sda = !(sda_low || o_sda_oe);
   pxs_regs #(.STEP_CYCLES(20)) uut (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_scl(scl), .i_sda(sda), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
      .i_prox_hit(i_prox_hit), .o_prox_irq(o_prox_irq),
      .o_osc_run(o_osc_run), .o_accum_active(o_acc), .o_adc_active(o_adc));
   pxs_host host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl),
      .o_sda_low(sda_low));
   // --
   // Tasks
   // --
   task automatic chk(input string n, input logic [7:0] s, e);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s exp %h seen %h", n, e, s);
      end
   endtask
   // One byte; 0xff marks a read, so its ack is not checked
   task automatic by(input logic [7:0] w, input logic nak);
      host.xfer(w, nak, r);
      if (w != 8'hff)
         chk("ack", 8'(r[0]), 8'h00);
   endtask
   // Command unless zero, then n data bytes
   task automatic wr(input logic [7:0] c, d0, d1, input int n);
      host.start();
      by(8'h54, 1'b1);
      if (c != 8'h00) by(c, 1'b1);
      if (n > 0) by(d0, 1'b1);
      if (n > 1) by(d1, 1'b1);
      host.stop();
   endtask
   task automatic rd(input logic [7:0] c, e0, e1);
      if (c != 8'h00) wr(c, 8'h00, 8'h00, 0);
      host.start();
      by(8'h55, 1'b1);
      by(8'hff, 1'b0);
      chk("rd0", r[8:1], e0);
      by(8'hff, 1'b1);
      chk("rd1", r[8:1], e1);
      host.stop();
   endtask
   // Bounded wait, so a missing interrupt cannot hang
   task automatic wait_irq;
      for (int k = 0; k < 9000 && o_prox_irq !== 1'b1; k++)
         @(posedge i_clk);
      #1;
      chk("irq", 8'(o_prox_irq), 8'h01);
   endtask
   task automatic complete_run;
      if (fail_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // 40 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   // Watchdog, about four times the expected run
   initial begin
      repeat (40000) @(posedge i_clk);
      fail_count++;
      complete_run;
   end
   initial begin
      i_rst_b = 1'b0;
      i_prox_hit = 1'b1;
      repeat (5) @(posedge i_clk);
      #1 i_rst_b = 1'b1;
      repeat (4) @(posedge i_clk);
      rd(8'ha2, 8'hff, 8'hff);
      wr(8'h83, 8'hfe, 8'h00, 1);
      wr(8'h00, 8'h7d, 8'h00, 1);
      rd(8'h00, 8'h7d, 8'h7d);
      wr(8'h8d, 8'hff, 8'h00, 1);
      rd(8'h00, 8'h02, 8'h02);
      chk("sda_o", 8'(o_sda_o), 8'h00);
      wr(8'ha0, 8'h65, 8'h00, 2);
      rd(8'ha0, 8'h65, 8'h00);
      chk("osc", 8'(o_osc_run), 8'h01);
      wait_irq;
      wr(8'he0, 8'h00, 8'h00, 0);
      chk("irq", 8'(o_prox_irq), 8'h01);
      wr(8'he5, 8'h00, 8'h00, 0);
      chk("irq", 8'(o_prox_irq), 8'h00);
      wait_irq;
      wr(8'ha0, 8'h00, 8'h00, 1);
      chk("osc", 8'(o_osc_run), 8'h00);
      complete_run;
   end
endmodule // test_pxs_regs

`default_nettype wire
